/* include/wdw_pkg.sv */
package wdw_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  // System clock and nominal oscillator rate, both in kHz.
  localparam real CLK_FREQ_KHZ = 100000.0;
  localparam real RC_FREQ_KHZ = 32.767;
  // System clock cycles per oscillator period, truncated.
  localparam int RC_DIV_CYCLES = $rtoi(CLK_FREQ_KHZ / RC_FREQ_KHZ);
  localparam int RC_CNT_W = 12;
  // Prescaler terminal counts for divide-by-32 and divide-by-128.
  localparam logic [6:0] PRE32_LAST = 7'h1f;
  localparam logic [6:0] PRE128_LAST = 7'h7f;
  localparam int PRE32_SHIFT = 5;
  localparam int PRE128_SHIFT = 7;
  localparam int POST_W = 15;
  localparam int ELAPSED_W = 22;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] RSTCTL_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // Field positions in the reset control register.
  localparam int RC_IDLE_BIT = 2;
  localparam int RC_SLEEP_BIT = 3;
  localparam int RC_TIMEOUT_BIT = 4;
  localparam int RC_SOFTEN_BIT = 5;

  // Status register: elapsed count, window-open and running bits.
  localparam int ST_WINDOW_BIT = 22;
  localparam int ST_RUN_BIT = 23;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Watchdog configuration word, low byte.
  typedef struct packed {
    logic always_on_fuse;
    logic window_disable;
    logic spare;
    logic prescale_select;
    logic [3:0] postscale_select;
  } wdw_cfg_t;

  // Non-window, divide-by-128, ratio 1:32,768, software enabled.
  localparam logic [7:0] CFG_RESET = 8'h5f;

endpackage : wdw_pkg

/* rtl/wdw_stage.sv */
`timescale 1ns/1ps

// Wrapping counter stage: counts steps and wraps after the given limit.
module wdw_stage #(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic step,
  input wire logic [W-1:0] limit,
  output logic [W-1:0] count,
  output logic wrap
);

  logic [W-1:0] count_q;

  // The wrap is combinational so stages chain within one cycle.
  assign wrap = step && !clear && (count_q >= limit);
  assign count = count_q;

  // Clear dominates a step; a limit lowered below the count wraps at once.
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      count_q <= '0;
    end else if (step) begin
      count_q <= (count_q >= limit) ? '0 : count_q + W'(1);
    end
  end

endmodule : wdw_stage

/* rtl/wdw_watchdog.sv */
`timescale 1ns/1ps

module wdw_watchdog #(
  parameter int RC_DIV = wdw_pkg::RC_DIV_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic kick_instruction,
  input wire logic power_save_instruction,
  input wire logic power_save_idle,
  input wire logic power_save_exit,
  input wire logic clock_switch_done,
  output logic low_power_rc_clock_enable,
  output logic device_reset,
  output logic wake,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wdw_pkg::wdw_cfg_t cfg_q;
  logic soft_enable_q, timeout_flag_q, sleep_flag_q, idle_flag_q;
  logic in_ps_q, rc_en_q, dev_rst_q, wake_q;
  logic running, clr, rc_tick, pre_wrap, post_wrap, timeout;
  logic early_kick, window_open, kick_now;
  logic [wdw_pkg::RC_CNT_W-1:0] rc_cnt;
  logic [6:0] pre_cnt, pre_last;
  logic [wdw_pkg::POST_W-1:0] post_cnt, post_last;
  logic [wdw_pkg::ELAPSED_W-1:0] elapsed, threshold;
  logic [4:0] shift;
  localparam int RC_LAST = RC_DIV - 1;

  // AXI slave state.
  logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic wstrb0_q;
  logic [1:0] bresp_q, rresp_q;
  logic do_write, wr_rstctl, wr_cfg;

  // ----------------------------------------------------------------
  // Enable and counting chain
  // ----------------------------------------------------------------
  // The fuse overrides the software enable completely.
  assign running = cfg_q.always_on_fuse || soft_enable_q;

  // Kicks only count while the core executes, not while it sleeps.
  assign kick_now = kick_instruction && !in_ps_q;

  // Any of these restarts the chain; a timeout wraps it by itself and is left out to avoid a loop.
  assign clr = !running || dev_rst_q || clock_switch_done
               || power_save_instruction || kick_now
               || (in_ps_q && power_save_exit);

  // Prescaler terminal count from the select bit.
  assign pre_last = cfg_q.prescale_select ? wdw_pkg::PRE128_LAST : wdw_pkg::PRE32_LAST;
  // Postscale ratio two to the power n, held as its last count.
  assign post_last = ~({wdw_pkg::POST_W{1'b1}} << cfg_q.postscale_select);

  // RC oscillator model: a divider of the system clock, gated by enable.
  wdw_stage #(.W(wdw_pkg::RC_CNT_W)) u_rc (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(!rc_en_q),
    .step(1'b1),
    .limit(RC_LAST[wdw_pkg::RC_CNT_W-1:0]),
    .count(rc_cnt),
    .wrap(rc_tick)
  );

  // Prescaler: 1 ms or 4 ms basic period at the nominal rate.
  wdw_stage #(.W(7)) u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(clr),
    .step(rc_tick),
    .limit(pre_last),
    .count(pre_cnt),
    .wrap(pre_wrap)
  );

  // Postscaler: the timeout is the prescaler period times the ratio.
  wdw_stage #(.W(wdw_pkg::POST_W)) u_post (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(clr),
    .step(pre_wrap),
    .limit(post_last),
    .count(post_cnt),
    .wrap(post_wrap)
  );

  assign timeout = running && post_wrap;

  // Elapsed oscillator ticks and three quarters of the full period.
  assign shift = cfg_q.prescale_select ? 5'(wdw_pkg::PRE128_SHIFT) : 5'(wdw_pkg::PRE32_SHIFT);
  assign elapsed = cfg_q.prescale_select
                 ? {post_cnt, pre_cnt}
                 : {2'b00, post_cnt, pre_cnt[4:0]};
  assign threshold = 22'h3 << (5'(cfg_q.postscale_select) + shift - 5'h2);
  assign window_open = elapsed >= threshold;

  // An early kick only matters in window mode.
  assign early_kick = running && kick_now && !cfg_q.window_disable && !window_open;

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  // The oscillator enable follows the watchdog's running state one cycle later.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_en_q <= 1'b0;
    end else begin
      rc_en_q <= running;
    end
  end

  // Reset pulse for a timeout in execution or an early kick.
  // A timeout in power-save only produces a wake pulse.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dev_rst_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      dev_rst_q <= (timeout && !in_ps_q) || early_kick;
      wake_q <= timeout && in_ps_q;
    end
  end

  // Power-save state: entered by the instruction, left by exit or wake.
  always_ff @(posedge aclk) begin
    if (!aresetn || dev_rst_q) begin
      in_ps_q <= 1'b0;
    end else if (power_save_instruction && !in_ps_q) begin
      in_ps_q <= 1'b1;
    end else if (in_ps_q && (power_save_exit || timeout)) begin
      in_ps_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Reset control register
  // ----------------------------------------------------------------
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign wr_rstctl = do_write && wstrb0_q && waddr_q == wdw_pkg::RSTCTL_OFS;
  assign wr_cfg = do_write && wstrb0_q && waddr_q == wdw_pkg::CFG_OFS;

  // Soft enable is written freely and dropped by any device reset.
  always_ff @(posedge aclk) begin
    if (!aresetn || dev_rst_q) begin
      soft_enable_q <= 1'b0;
    end else if (wr_rstctl) begin
      soft_enable_q <= wdata_q[wdw_pkg::RC_SOFTEN_BIT];
    end
  end

  // Sticky flags: writing 0 clears, writing 1 is ignored, a set wins.
  // The timeout flag survives the watchdog's own reset pulse.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timeout_flag_q <= 1'b0;
      sleep_flag_q <= 1'b0;
      idle_flag_q <= 1'b0;
    end else begin
      if (timeout || early_kick) begin
        timeout_flag_q <= 1'b1;
      end else if (wr_rstctl && !wdata_q[wdw_pkg::RC_TIMEOUT_BIT]) begin
        timeout_flag_q <= 1'b0;
      end
      // Left set after a wake; software clears them.
      if (power_save_instruction && !in_ps_q && !power_save_idle) begin
        sleep_flag_q <= 1'b1;
      end else if (wr_rstctl && !wdata_q[wdw_pkg::RC_SLEEP_BIT]) begin
        sleep_flag_q <= 1'b0;
      end
      if (power_save_instruction && !in_ps_q && power_save_idle) begin
        idle_flag_q <= 1'b1;
      end else if (wr_rstctl && !wdata_q[wdw_pkg::RC_IDLE_BIT]) begin
        idle_flag_q <= 1'b0;
      end
    end
  end

  // Configuration word; a device reset from the watchdog keeps it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= wdw_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      cfg_q <= wdata_q[7:0];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // Address and data are taken in either order; readies stay low
  // until the response is accepted, so one write is open at a time.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= wdw_pkg::RESP_OKAY;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
        waddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (waddr_q == wdw_pkg::CFG_OFS || waddr_q == wdw_pkg::RSTCTL_OFS)
                   ? wdw_pkg::RESP_OKAY : wdw_pkg::RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  // Data is sampled at the address handshake and held until taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= wdw_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= wdw_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        wdw_pkg::CFG_OFS: rdata_q <= {24'h0, cfg_q};
        wdw_pkg::RSTCTL_OFS: rdata_q <= {26'h0, soft_enable_q, timeout_flag_q, sleep_flag_q, idle_flag_q, 2'h0};
        wdw_pkg::STATUS_OFS: rdata_q <= {8'h0, running, window_open, elapsed};
        default: begin
          rdata_q <= 32'h0;
          rresp_q <= wdw_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign low_power_rc_clock_enable = rc_en_q;
  assign device_reset = dev_rst_q;
  assign wake = wake_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence timeout_running_s;
    timeout && !in_ps_q;
  endsequence
  sequence reset_with_flag_s;
    dev_rst_q && timeout_flag_q;
  endsequence

  rc_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    running && !dev_rst_q |=> low_power_rc_clock_enable)
    else $error("Oscillator not enabled while running.");

  pre_limit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pre_wrap |-> pre_cnt == (cfg_q.prescale_select ? 7'h7f : 7'h1f))
    else $error("Prescaler wrapped at the wrong count.");

  post_ratio_a: assert property (@(posedge aclk) disable iff (!aresetn)
    post_wrap |-> 32'(post_cnt) + 32'h1 == (32'h1 << cfg_q.postscale_select))
    else $error("Postscaler ratio is wrong.");

  switch_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clock_switch_done |=> pre_cnt == 7'h0 && post_cnt == '0)
    else $error("Clock switch did not clear the counters.");

  kick_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (kick_now || power_save_instruction) |=> pre_cnt == 7'h0 && post_cnt == '0)
    else $error("Kick or power-save did not clear the counters.");

  sleep_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout && in_ps_q |=> wake && !device_reset && !in_ps_q)
    else $error("Timeout in power-save did not wake cleanly.");

  enable_mux_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg_q.always_on_fuse && !soft_enable_q |=> low_power_rc_clock_enable == $past(running) && rc_cnt == '0
      || !low_power_rc_clock_enable)
    else $error("Watchdog ran while disabled.");

  soft_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    device_reset |=> !soft_enable_q)
    else $error("Soft enable survived a device reset.");

  early_kick_a: assert property (@(posedge aclk) disable iff (!aresetn)
    early_kick |=> device_reset ##1 !device_reset)
    else $error("Early kick did not give one reset pulse.");

  flag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout_flag_q && !wr_rstctl |=> timeout_flag_q)
    else $error("Timeout flag cleared without software.");

  run_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout_running_s |=> reset_with_flag_s)
    else $error("Timeout did not reset and flag.");

endmodule : wdw_watchdog

/* sim/tb_watchdog_timer_with_window.sv */
`timescale 1ns/1ps

module tb_watchdog_timer_with_window;
  // ----------------------------------------------------------------
  // Stimulus and design
  // ----------------------------------------------------------------
  // A small oscillator divider keeps every period short.
  localparam int RCD = 2;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] ev = 4'h0; // Kick, power save, exit, clock switch.
  logic ps_idle = 1'b0;
  logic low_en;
  logic dev_rst;
  logic wake;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [31:0] rng = 32'h683f;
  logic [7:0] cfg;
  int p;
  int fails = 0;
  int samples_checked = 0;

  wdw_watchdog #(.RC_DIV(RCD)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .kick_instruction(ev[0]), .power_save_instruction(ev[1]),
    .power_save_idle(ps_idle), .power_save_exit(ev[2]), .clock_switch_done(ev[3]),
    .low_power_rc_clock_enable(low_en), .device_reset(dev_rst), .wake(wake),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready)
  );

  // The clock inverts every half period of 5 ns.
  initial begin
    forever #5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Timeout in system cycles for a configuration byte.
  function automatic int period(input logic [7:0] c);
    wdw_pkg::wdw_cfg_t f;
    f = c;
    return (RCD << (f.prescale_select ? wdw_pkg::PRE128_SHIFT : wdw_pkg::PRE32_SHIFT)) << f.postscale_select;
  endfunction : period

  task automatic expect32(input logic [31:0] got, input logic [31:0] want, input string what);
    samples_checked++;
    if (got !== want) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask : expect32

  // Address and data are offered together; bready stays up until the answer.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    int n;
    r = 2'h3;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        n = 1000;
      end
    end
    expect32(r, er, "write response");
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    d = 32'hx;
    r = 2'h3;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        n = 1000;
      end
    end
    expect32(d, ed, "read data");
    expect32(r, er, "read response");
  endtask : rchk

  // Writes the configuration and the reset control register, then draws new random bits.
  task automatic set_run(input logic [7:0] c, input logic [31:0] rc);
    cfg = c;
    p = period(c);
    wr(wdw_pkg::CFG_OFS, {24'h0, c}, wdw_pkg::RESP_OKAY);
    wr(wdw_pkg::RSTCTL_OFS, rc, wdw_pkg::RESP_OKAY);
    ps_idle <= rng[3];
    rng = xs(rng);
  endtask : set_run

  task automatic pulse(input int i);
    @(posedge aclk);
    ev[i] <= 1'b1;
    @(posedge aclk);
    ev[i] <= 1'b0;
  endtask : pulse

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask : idle

  // Counts edges from the clearing event until a reset or wake pulse.
  task automatic wait_evt(input int pe, input logic ew, input int c0);
    int c;
    c = c0;
    // Look after the edge that ended the pulse, so an immediate reset is seen.
    #1;
    while (c <= pe + 8 && !(dev_rst === 1'b1 || wake === 1'b1)) begin
      @(posedge aclk);
      #1;
      c++;
    end
    expect32(c >= pe - 3 && c <= pe + 4, 1'b1, "timeout span");
    expect32({wake, dev_rst}, {ew, !ew}, "timeout action");
    @(posedge aclk);
    #1;
    expect32({wake, dev_rst}, 2'b00, "pulse length");
  endtask : wait_evt

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    int hits;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(wdw_pkg::CFG_OFS, {24'h0, wdw_pkg::CFG_RESET}, wdw_pkg::RESP_OKAY);
    rchk(wdw_pkg::RSTCTL_OFS, 32'h0, wdw_pkg::RESP_OKAY);
    rchk(8'h0c, 32'h0, wdw_pkg::RESP_SLVERR);
    wr(8'h10, rng, wdw_pkg::RESP_SLVERR);
    // Both prescales, four postscale codes; the flag is never cleared so it must stay.
    for (int k = 0; k < 8; k++) begin
      set_run({2'b01, rng[0], k[2], 2'b00, k[1:0]}, 32'h30);
      @(posedge aclk);
      #1;
      expect32(low_en, 1'b1, "oscillator on");
      pulse(0);
      wait_evt(p, 1'b0, 0);
      rchk(wdw_pkg::RSTCTL_OFS, 32'h10, wdw_pkg::RESP_OKAY);
    end
    wr(wdw_pkg::RSTCTL_OFS, 32'h0, wdw_pkg::RESP_OKAY);
    rchk(wdw_pkg::RSTCTL_OFS, 32'h0, wdw_pkg::RESP_OKAY);
    // Always-on runs with soft enable clear.
    set_run({2'b11, 1'b0, rng[1], 4'h0}, 32'h0);
    expect32(low_en, 1'b1, "oscillator forced");
    pulse(3);
    wait_evt(p, 1'b0, 0);
    // Soft enable clear and fuse clear: nothing may happen.
    set_run({2'b01, 1'b0, rng[1], 4'h0}, 32'h0);
    hits = 0;
    repeat (2 * p) begin
      @(posedge aclk);
      #1;
      if (dev_rst === 1'b1 || wake === 1'b1) hits++;
    end
    expect32(hits, 0, "disabled events");
    expect32(low_en, 1'b0, "oscillator off");
    rchk(wdw_pkg::STATUS_OFS, 32'h0, wdw_pkg::RESP_OKAY);
    // A clock switch half way restarts the count.
    set_run({2'b01, 1'b0, rng[1], 4'h1}, 32'h20);
    pulse(0);
    idle(p / 2);
    pulse(3);
    wait_evt(p, 1'b0, 0);
    // Sleep or idle: counting goes on, kicks are ignored, a timeout only wakes.
    for (int k = 0; k < 2; k++) begin
      set_run({2'b01, 1'b0, rng[1], 4'h0}, 32'h20);
      pulse(1);
      idle(p / 2);
      pulse(0);
      wait_evt(p, 1'b1, p / 2 + 2);
      rchk(wdw_pkg::RSTCTL_OFS, ps_idle ? 32'h34 : 32'h38, wdw_pkg::RESP_OKAY);
      wr(wdw_pkg::RSTCTL_OFS, 32'h20, wdw_pkg::RESP_OKAY);
      rchk(wdw_pkg::RSTCTL_OFS, 32'h20, wdw_pkg::RESP_OKAY);
    end
    // Leaving power save half way restarts the count in normal execution.
    set_run({2'b01, 1'b0, rng[1], 4'h0}, 32'h20);
    pulse(1);
    idle(p / 2);
    pulse(2);
    wait_evt(p, 1'b0, 0);
    rchk(wdw_pkg::RSTCTL_OFS, ps_idle ? 32'h14 : 32'h18, wdw_pkg::RESP_OKAY);
    // Window mode: an early kick resets at once, a late kick restarts the count.
    set_run({2'b00, 1'b0, rng[1], 4'h1}, 32'h20);
    pulse(3);
    idle(p / 4);
    pulse(0);
    wait_evt(2, 1'b0, 0);
    rchk(wdw_pkg::RSTCTL_OFS, 32'h10, wdw_pkg::RESP_OKAY);
    set_run({2'b00, 1'b0, rng[1], 4'h1}, 32'h20);
    pulse(3);
    idle(7 * p / 8);
    pulse(0);
    wait_evt(p, 1'b0, 0);
    conclude();
  end

  // The whole run needs far fewer cycles than this limit.
  initial begin
    repeat (60000) @(posedge aclk);
    fails++;
    conclude();
  end
endmodule : tb_watchdog_timer_with_window
